/* File: dcc_pkg.sv */
// dcc_pkg: constants, types and calendar helpers for the dst clock
// assumes: 32-bit register port, byte addresses on aligned words
package dcc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_USR_START = 8'h04;
  localparam logic [7:0] ADDR_USR_END = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0c;
  localparam logic [7:0] ADDR_TIME = 8'h10;
  localparam logic [7:0] ADDR_DATE = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // field positions
  localparam int CTRL_DST_EN = 0;
  localparam int CTRL_SYNC_EN = 1;
  localparam int CTRL_PRESET_LSB = 4;
  localparam int USR_MONTH_LSB = 0;
  localparam int USR_DAY_LSB = 8;
  localparam int TIME_SEC_LSB = 0;
  localparam int TIME_MIN_LSB = 8;
  localparam int TIME_HOUR_LSB = 16;
  localparam int DATE_DAY_LSB = 0;
  localparam int DATE_MONTH_LSB = 8;
  localparam int DATE_YEAR_LSB = 16;
  localparam int DATE_WDAY_LSB = 24;
  localparam int STAT_SUMMER = 0;
  localparam int STAT_MAINS = 1;

  // packed time: {year, month, day, wday, hour, min, sec}
  localparam int TIME_W = 36;

  // preset selection
  typedef enum logic [2:0] {
    dst_preset_eu = 3'b000,
    dst_preset_uk = 3'b001,
    dst_preset_america_legacy = 3'b010,
    dst_preset_america_current = 3'b011,
    dst_preset_australia = 3'b100,
    dst_preset_tasmania = 3'b101,
    dst_preset_new_zealand = 3'b110,
    dst_preset_user = 3'b111
  } dcc_preset_e;

  // reset values
  localparam logic RST_DST_EN = 1'b0;
  localparam logic RST_SYNC_EN = 1'b0;
  localparam dcc_preset_e RST_PRESET = dst_preset_eu;
  localparam logic [7:0] RST_OFFSET = 8'h3c;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [4:0] RST_DAY = 5'h01;

  // conversion figures
  localparam logic [7:0] OFFSET_MAX = 8'hb4;
  localparam logic [7:0] PRESET_DELTA = 8'h3c;
  localparam logic [4:0] HR_1 = 5'h01;
  localparam logic [4:0] HR_2 = 5'h02;
  localparam logic [4:0] HR_3 = 5'h03;
  localparam logic [3:0] MON_MAR = 4'h3;
  localparam logic [3:0] MON_APR = 4'h4;
  localparam logic [3:0] MON_OCT = 4'ha;
  localparam logic [3:0] MON_NOV = 4'hb;
  localparam logic [2:0] WDAY_SUN = 3'h0;

  function automatic logic [4:0] dcc_days_in(input logic [3:0] mon,
                                             input logic [6:0] yr);
    unique case (mon)
      4'h2: dcc_days_in = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: dcc_days_in = 5'h1e;
      default: dcc_days_in = 5'h1f;
    endcase
  endfunction : dcc_days_in

endpackage : dcc_pkg

/* File: dcc_rule.sv */
// dcc_rule: decodes transition days and hours for the selected preset
// assumes: calendar fields valid, weekday 0 is sunday
`timescale 1ns/1ns
`default_nettype none
module dcc_rule
  import dcc_pkg::*;
(
  input wire dcc_preset_e preset_i,
  input wire logic [3:0] usr_start_mon_i,
  input wire logic [4:0] usr_start_day_i,
  input wire logic [3:0] usr_end_mon_i,
  input wire logic [4:0] usr_end_day_i,
  input wire logic [7:0] usr_offset_i,
  input wire logic [3:0] month_i,
  input wire logic [4:0] day_i,
  input wire logic [2:0] wday_i,
  input wire logic [6:0] year_i,
  output logic start_day_o,
  output logic end_day_o,
  output logic [4:0] start_hr_o,
  output logic [4:0] end_hr_o,
  output logic [7:0] delta_o
);

  logic sun;
  logic first_sun;
  logic second_sun;
  logic third_sun;
  logic last_sun;
  logic [5:0] day_plus7;

  assign sun = (wday_i == WDAY_SUN);
  assign day_plus7 = {1'b0, day_i} + 6'h07;
  assign first_sun = sun && (day_i <= 5'h07);
  assign second_sun = sun && (day_i >= 5'h08) && (day_i <= 5'h0e);
  assign third_sun = sun && (day_i >= 5'h0f) && (day_i <= 5'h15);
  assign last_sun = sun &&
      (day_plus7 > {1'b0, dcc_days_in(month_i, year_i)});

  always_comb begin
    start_day_o = 1'b0;
    end_day_o = 1'b0;
    start_hr_o = HR_2;
    end_hr_o = HR_3;
    delta_o = PRESET_DELTA;
    unique case (preset_i)
      dst_preset_eu: begin
        start_day_o = last_sun && (month_i == MON_MAR);
        end_day_o = last_sun && (month_i == MON_OCT);
      end
      dst_preset_uk: begin
        start_day_o = last_sun && (month_i == MON_MAR);
        end_day_o = last_sun && (month_i == MON_OCT);
        start_hr_o = HR_1;
        end_hr_o = HR_2;
      end
      dst_preset_america_legacy: begin
        start_day_o = first_sun && (month_i == MON_APR);
        end_day_o = last_sun && (month_i == MON_OCT);
        end_hr_o = HR_2;
      end
      dst_preset_america_current: begin
        start_day_o = second_sun && (month_i == MON_MAR);
        end_day_o = first_sun && (month_i == MON_NOV);
        end_hr_o = HR_2;
      end
      dst_preset_australia: begin
        start_day_o = last_sun && (month_i == MON_OCT);
        end_day_o = last_sun && (month_i == MON_MAR);
      end
      dst_preset_tasmania: begin
        start_day_o = first_sun && (month_i == MON_OCT);
        end_day_o = last_sun && (month_i == MON_MAR);
      end
      dst_preset_new_zealand: begin
        start_day_o = first_sun && (month_i == MON_OCT);
        end_day_o = third_sun && (month_i == MON_MAR);
      end
      dst_preset_user: begin
        start_day_o = (month_i == usr_start_mon_i) &&
                      (day_i == usr_start_day_i);
        end_day_o = (month_i == usr_end_mon_i) &&
                    (day_i == usr_end_day_i);
        delta_o = usr_offset_i;
      end
    endcase
  end

endmodule : dcc_rule
`default_nettype wire

/* File: dcc_bcast.sv */
// dcc_bcast: snapshots the clock and pulses it to expansion modules
// assumes: send request comes the cycle after the time has settled
`timescale 1ns/1ns
`default_nettype none
module dcc_bcast
  import dcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic send_i,
  input wire logic [TIME_W-1:0] time_i,
  output logic bcast_valid_o,
  output logic [TIME_W-1:0] bcast_time_o
);

  logic valid_ff;
  logic nxt_valid;
  logic [TIME_W-1:0] data_ff;
  logic [TIME_W-1:0] nxt_data;

  always_comb begin
    nxt_valid = send_i;
    nxt_data = send_i ? time_i : data_ff;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      valid_ff <= nxt_valid;
      data_ff <= nxt_data;
    end
  end

  assign bcast_valid_o = valid_ff;
  assign bcast_time_o = data_ff;

endmodule : dcc_bcast
`default_nettype wire

/* File: dcc_top.sv */
// dcc_top: calendar clock with seasonal conversion, sync and broadcast
// assumes: tick_sec_i is a one-cycle pulse per second, mains_on_i high
// in run or stop, low while running from backup buffering
`timescale 1ns/1ns
`default_nettype none
module dcc_top
  import dcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic tick_sec_i,
  input wire logic mains_on_i,
  input wire logic ext_valid_i,
  input wire logic [TIME_W-1:0] ext_time_i,
  output logic summer_o,
  output logic bcast_valid_o,
  output logic [TIME_W-1:0] bcast_time_o
);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic dst_en_ff;
  logic nxt_dst_en;
  logic sync_en_ff;
  logic nxt_sync_en;
  dcc_preset_e preset_ff;
  dcc_preset_e nxt_preset;
  logic [3:0] us_mon_ff;
  logic [3:0] nxt_us_mon;
  logic [4:0] us_day_ff;
  logic [4:0] nxt_us_day;
  logic [3:0] ue_mon_ff;
  logic [3:0] nxt_ue_mon;
  logic [4:0] ue_day_ff;
  logic [4:0] nxt_ue_day;
  logic [7:0] offset_ff;
  logic [7:0] nxt_offset;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0] wr_off;

  assign wr_off = wdata_i[7:0];

  always_comb begin
    nxt_dst_en = dst_en_ff;
    nxt_sync_en = sync_en_ff;
    nxt_preset = preset_ff;
    nxt_us_mon = us_mon_ff;
    nxt_us_day = us_day_ff;
    nxt_ue_mon = ue_mon_ff;
    nxt_ue_day = ue_day_ff;
    nxt_offset = offset_ff;
    if (wr_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          nxt_dst_en = wdata_i[CTRL_DST_EN];
          nxt_sync_en = wdata_i[CTRL_SYNC_EN];
          nxt_preset = dcc_preset_e'(wdata_i[CTRL_PRESET_LSB +: 3]);
        end
        ADDR_USR_START: begin
          nxt_us_mon = wdata_i[USR_MONTH_LSB +: 4];
          nxt_us_day = wdata_i[USR_DAY_LSB +: 5];
        end
        ADDR_USR_END: begin
          nxt_ue_mon = wdata_i[USR_MONTH_LSB +: 4];
          nxt_ue_day = wdata_i[USR_DAY_LSB +: 5];
        end
        ADDR_OFFSET: begin
          // out-of-range offsets saturate
          nxt_offset = (wr_off > OFFSET_MAX) ? OFFSET_MAX : wr_off;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dst_en_ff <= RST_DST_EN;
      sync_en_ff <= RST_SYNC_EN;
      preset_ff <= RST_PRESET;
      us_mon_ff <= RST_MONTH;
      us_day_ff <= RST_DAY;
      ue_mon_ff <= RST_MONTH;
      ue_day_ff <= RST_DAY;
      offset_ff <= RST_OFFSET;
    end else begin
      dst_en_ff <= nxt_dst_en;
      sync_en_ff <= nxt_sync_en;
      preset_ff <= nxt_preset;
      us_mon_ff <= nxt_us_mon;
      us_day_ff <= nxt_us_day;
      ue_mon_ff <= nxt_ue_mon;
      ue_day_ff <= nxt_ue_day;
      offset_ff <= nxt_offset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // calendar state

  logic [5:0] sec_ff;
  logic [5:0] nxt_sec;
  logic [5:0] min_ff;
  logic [5:0] nxt_min;
  logic [4:0] hour_ff;
  logic [4:0] nxt_hour;
  logic [4:0] day_ff;
  logic [4:0] nxt_day;
  logic [3:0] month_ff;
  logic [3:0] nxt_month;
  logic [6:0] year_ff;
  logic [6:0] nxt_year;
  logic [2:0] wday_ff;
  logic [2:0] nxt_wday;
  logic summer_ff;
  logic nxt_summer;
  logic por_ff;
  logic send_ff;
  logic nxt_send;
  logic start_day;
  logic end_day;
  logic [4:0] start_hr;
  logic [4:0] end_hr;
  logic [7:0] delta;
  logic set_time;
  logic set_date;
  logic ext_load;
  logic quiet;
  logic at_hour;
  logic fwd_go;
  logic bwd_go;
  logic hour_wrap;
  logic [10:0] tod_now;
  logic [10:0] tod_new;
  logic [TIME_W-1:0] time_now;

  dcc_rule u_rule (
    .preset_i(preset_ff),
    .usr_start_mon_i(us_mon_ff),
    .usr_start_day_i(us_day_ff),
    .usr_end_mon_i(ue_mon_ff),
    .usr_end_day_i(ue_day_ff),
    .usr_offset_i(offset_ff),
    .month_i(month_ff),
    .day_i(day_ff),
    .wday_i(wday_ff),
    .year_i(year_ff),
    .start_day_o(start_day),
    .end_day_o(end_day),
    .start_hr_o(start_hr),
    .end_hr_o(end_hr),
    .delta_o(delta)
  );

  assign set_time = wr_i && (addr_i == ADDR_TIME);
  assign set_date = wr_i && (addr_i == ADDR_DATE);
  assign ext_load = ext_valid_i && sync_en_ff;
  // conversion waits for a cycle free of loads and ticks
  assign quiet = !set_time && !set_date && !ext_load && !tick_sec_i;
  assign at_hour = (sec_ff == 6'h00) && (min_ff == 6'h00);
  assign fwd_go = quiet && at_hour && dst_en_ff && mains_on_i &&
                  start_day && (hour_ff == start_hr) && !summer_ff;
  assign bwd_go = quiet && at_hour && dst_en_ff && mains_on_i &&
                  end_day && (hour_ff == end_hr) && summer_ff;
  assign hour_wrap = tick_sec_i && (sec_ff == 6'h3b) && (min_ff == 6'h3b);
  assign tod_now = 11'(hour_ff) * 11'd60 + 11'(min_ff);
  assign tod_new = fwd_go ? (tod_now + 11'(delta))
                          : (tod_now - 11'(delta));
  assign time_now = {year_ff, month_ff, day_ff, wday_ff,
                     hour_ff, min_ff, sec_ff};

  always_comb begin
    {nxt_year, nxt_month, nxt_day, nxt_wday,
     nxt_hour, nxt_min, nxt_sec} = time_now;
    nxt_summer = summer_ff;
    if (set_time || set_date) begin
      if (set_time) begin
        nxt_sec = wdata_i[TIME_SEC_LSB +: 6];
        nxt_min = wdata_i[TIME_MIN_LSB +: 6];
        nxt_hour = wdata_i[TIME_HOUR_LSB +: 5];
      end else begin
        nxt_day = wdata_i[DATE_DAY_LSB +: 5];
        nxt_month = wdata_i[DATE_MONTH_LSB +: 4];
        nxt_year = wdata_i[DATE_YEAR_LSB +: 7];
        nxt_wday = wdata_i[DATE_WDAY_LSB +: 3];
      end
    end else if (ext_load) begin
      {nxt_year, nxt_month, nxt_day, nxt_wday,
       nxt_hour, nxt_min, nxt_sec} = ext_time_i;
    end else if (fwd_go || bwd_go) begin
      // both jumps stay within the same day
      nxt_hour = 5'(tod_new / 11'd60);
      nxt_min = 6'(tod_new % 11'd60);
      nxt_summer = fwd_go;
    end else if (tick_sec_i) begin
      nxt_sec = sec_ff + 6'h01;
      if (sec_ff == 6'h3b) begin
        nxt_sec = 6'h00;
        nxt_min = min_ff + 6'h01;
        if (min_ff == 6'h3b) begin
          nxt_min = 6'h00;
          nxt_hour = hour_ff + 5'h01;
          if (hour_ff == 5'h17) begin
            nxt_hour = 5'h00;
            nxt_wday = (wday_ff == 3'h6) ? 3'h0 : wday_ff + 3'h1;
            nxt_day = day_ff + 5'h01;
            if (day_ff >= dcc_days_in(month_ff, year_ff)) begin
              nxt_day = 5'h01;
              nxt_month = month_ff + 4'h1;
              if (month_ff >= 4'hc) begin
                nxt_month = 4'h1;
                nxt_year = year_ff + 7'h01;
              end
            end
          end
        end
      end
    end
  end

  // one send per time or date write, conversion, hour wrap on mains and power-up (none for sync loads), after the new time has been registered
  always_comb begin
    nxt_send = por_ff || set_time || set_date || fwd_go || bwd_go ||
               (hour_wrap && mains_on_i && !set_time && !set_date &&
                !ext_load);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_ff <= 6'h00;
      min_ff <= 6'h00;
      hour_ff <= 5'h00;
      day_ff <= RST_DAY;
      month_ff <= RST_MONTH;
      year_ff <= 7'h00;
      wday_ff <= 3'h0;
      summer_ff <= 1'b0;
      por_ff <= 1'b1;
      send_ff <= 1'b0;
    end else begin
      sec_ff <= nxt_sec;
      min_ff <= nxt_min;
      hour_ff <= nxt_hour;
      day_ff <= nxt_day;
      month_ff <= nxt_month;
      year_ff <= nxt_year;
      wday_ff <= nxt_wday;
      summer_ff <= nxt_summer;
      por_ff <= 1'b0;
      send_ff <= nxt_send;
    end
  end

  dcc_bcast u_bcast (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .send_i(send_ff),
    .time_i(time_now),
    .bcast_valid_o(bcast_valid_o),
    .bcast_time_o(bcast_time_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: begin
          nxt_rdata[CTRL_DST_EN] = dst_en_ff;
          nxt_rdata[CTRL_SYNC_EN] = sync_en_ff;
          nxt_rdata[CTRL_PRESET_LSB +: 3] = preset_ff;
        end
        ADDR_USR_START: begin
          nxt_rdata[USR_MONTH_LSB +: 4] = us_mon_ff;
          nxt_rdata[USR_DAY_LSB +: 5] = us_day_ff;
        end
        ADDR_USR_END: begin
          nxt_rdata[USR_MONTH_LSB +: 4] = ue_mon_ff;
          nxt_rdata[USR_DAY_LSB +: 5] = ue_day_ff;
        end
        ADDR_OFFSET: nxt_rdata[7:0] = offset_ff;
        ADDR_TIME: begin
          nxt_rdata[TIME_SEC_LSB +: 6] = sec_ff;
          nxt_rdata[TIME_MIN_LSB +: 6] = min_ff;
          nxt_rdata[TIME_HOUR_LSB +: 5] = hour_ff;
        end
        ADDR_DATE: begin
          nxt_rdata[DATE_DAY_LSB +: 5] = day_ff;
          nxt_rdata[DATE_MONTH_LSB +: 4] = month_ff;
          nxt_rdata[DATE_YEAR_LSB +: 7] = year_ff;
          nxt_rdata[DATE_WDAY_LSB +: 3] = wday_ff;
        end
        ADDR_STATUS: begin
          nxt_rdata[STAT_SUMMER] = summer_ff;
          nxt_rdata[STAT_MAINS] = mains_on_i;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign summer_o = summer_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_eu_spring: assert property (
    (fwd_go && preset_ff == dst_preset_eu) |=>
      (hour_ff == 5'h03) && (min_ff == 6'h00) && summer_ff)
    else $error("eu advance did not land on 03:00");

  a_uk_autumn: assert property (
    (bwd_go && preset_ff == dst_preset_uk) |->
      (month_ff == MON_OCT) ##1 (hour_ff == 5'h01) && !summer_ff)
    else $error("uk retard did not land on 01:00 in october");

  a_us_fall: assert property (
    (bwd_go && (preset_ff == dst_preset_america_legacy ||
                preset_ff == dst_preset_america_current)) |=>
      (hour_ff == 5'h01) && (min_ff == 6'h00))
    else $error("us retard did not land on 01:00");

  a_south_spring: assert property (
    (fwd_go && preset_ff >= dst_preset_australia &&
     preset_ff <= dst_preset_new_zealand) |->
      (month_ff == MON_OCT) && (wday_ff == WDAY_SUN))
    else $error("southern advance outside an october sunday");

  a_user_offset: assert property (
    (fwd_go && preset_ff == dst_preset_user) |=>
      (11'(hour_ff) * 11'd60 + 11'(min_ff) ==
       11'd120 + 11'($past(offset_ff))))
    else $error("user advance not 02:00 plus offset");

  a_offset_range: assert property (
    offset_ff <= OFFSET_MAX)
    else $error("offset above 180 minutes");

  a_mains_gate: assert property (
    (!mains_on_i || !dst_en_ff) |=> $stable(summer_ff))
    else $error("conversion without mains or enable");

  a_sync_load: assert property (
    (ext_valid_i && sync_en_ff && !wr_i) |=>
      (time_now == $past(ext_time_i)))
    else $error("external time not loaded");

  a_change_send: assert property (
    (fwd_go || bwd_go || set_time) |-> ##2
      bcast_valid_o && (bcast_time_o == $past(time_now, 1)))
    else $error("time change not broadcast");

  a_once_only: assert property (
    bwd_go |=> !bwd_go [*8])
    else $error("retard applied twice");

  c_advance: cover property (fwd_go);
  c_retard: cover property (bwd_go);
  c_hour_send: cover property (hour_wrap && mains_on_i);
  c_ext_load: cover property (ext_load);

endmodule : dcc_top
`default_nettype wire

/* File: dcc_far_model.sv */
// dcc_far_model: comms module sending time, expansion modules listening
// assumes: the bench clock and reset, push called from the bench
`timescale 1ns/1ns
`default_nettype none
module dcc_far_model
  import dcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic bcast_valid_i,
  input wire logic [TIME_W-1:0] bcast_time_i,
  output logic ext_valid_o,
  output logic [TIME_W-1:0] ext_time_o
);
  int bcast_seen;
  logic [TIME_W-1:0] last_bcast;
  initial begin
    ext_valid_o = 1'b0;
    ext_time_o = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // expansion side: count every broadcast and keep the latest
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bcast_seen <= 0;
      last_bcast <= '0;
    end else if (bcast_valid_i === 1'b1) begin
      bcast_seen <= bcast_seen + 1;
      last_bcast <= bcast_time_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // comms side: one-cycle time word, inverted data once idle
  task automatic push(input logic [TIME_W-1:0] t);
    @(posedge core_clk_i);
    ext_valid_o <= 1'b1;
    ext_time_o <= t;
    @(posedge core_clk_i);
    ext_valid_o <= 1'b0;
    ext_time_o <= ~t;
  endtask : push
endmodule : dcc_far_model
`default_nettype wire

/* File: dcc_top_tb_top.sv */
// dcc_top_tb_top: register-driven checks of the seasonal clock
// assumes: dcc_top and dcc_far_model compiled, 125 MHz clock
`timescale 1ns/1ns
`default_nettype none
module dcc_top_tb_top;
  import dcc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tick_sec_i = 1'b0;
  logic mains_on_i = 1'b1;
  logic [31:0] rdata_o;
  logic summer_o;
  logic ext_valid_i;
  logic [TIME_W-1:0] ext_time_i;
  logic bcast_valid_o;
  logic [TIME_W-1:0] bcast_time_o;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  // per preset: start mon, day, hour, hour after; end the same
  localparam logic [63:0] ROWS [8] = '{
    64'h031f0203_0a1b0302, 64'h031f0102_0a1b0201,
    64'h04070203_0a1b0201, 64'h030a0203_0b030201,
    64'h0a1b0203_031f0302, 64'h0a060203_031f0302,
    64'h0a060203_03110302, 64'h031f0204_0b010301};

  dcc_top dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tick_sec_i(tick_sec_i), .mains_on_i(mains_on_i),
    .ext_valid_i(ext_valid_i), .ext_time_i(ext_time_i),
    .summer_o(summer_o), .bcast_valid_o(bcast_valid_o),
    .bcast_time_o(bcast_time_o));
  dcc_far_model far (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .bcast_valid_i(bcast_valid_o), .bcast_time_i(bcast_time_o),
    .ext_valid_o(ext_valid_i), .ext_time_o(ext_time_i));

  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] tm(input logic [4:0] h,
                                     input logic [5:0] m,
                                     input logic [5:0] s);
    tm = {11'h000, h, 2'h0, m, 2'h0, s};
  endfunction : tm
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32
  task automatic chk36(input string nm, input logic [TIME_W-1:0] e,
                       input logic [TIME_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk36
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(posedge core_clk_i);
    chk32(nm, e, rdata_o);
  endtask : rdc
  // hour 0 first so no transition fires between the two writes
  task automatic set_clock(input logic [7:0] mon, input logic [7:0] day,
                           input logic [31:0] t);
    wr(ADDR_TIME, 32'h0);
    wr(ADDR_DATE, {9'h000, 7'h18, 4'h0, mon[3:0], 3'h0, day[4:0]});
    wr(ADDR_TIME, t);
  endtask : set_clock
  task automatic trans(input logic [7:0] mon, input logic [7:0] day,
                       input logic [7:0] hr, input logic [7:0] ex,
                       input logic sm);
    set_clock(mon, day, tm(hr[4:0], 6'h00, 6'h00));
    repeat (6) @(posedge core_clk_i);
    rdc("time", ADDR_TIME, tm(ex[4:0], 6'h00, 6'h00));
    rdc("status", ADDR_STATUS, {30'h0, mains_on_i, sm});
    chk32("bcast hour", {24'h0, ex}, {27'h0, far.last_bcast[16:12]});
    chk32("summer pin", {31'h0, sm}, {31'h0, summer_o});
  endtask : trans
  ////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk32("powerup bcast", 32'h1, far.bcast_seen);
    rdc("ctrl reset", ADDR_CTRL, 32'h0);
    rdc("offset reset", ADDR_OFFSET, 32'h3c);
    wr(ADDR_OFFSET, 32'hff);
    rdc("offset clamp", ADDR_OFFSET, 32'hb4);
    wr(ADDR_OFFSET, 32'h78);
    rdc("offset", ADDR_OFFSET, 32'h78);
    rdc("unmapped", 8'h40, 32'h0);
    trans(8'h03, 8'h1f, 8'h02, 8'h02, 1'b0);
    wr(ADDR_CTRL, 32'h1);
    mains_on_i <= 1'b0;
    trans(8'h03, 8'h1f, 8'h02, 8'h02, 1'b0);
    mains_on_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    rdc("mains back", ADDR_TIME, tm(5'h03, 6'h00, 6'h00));
    trans(8'h0a, 8'h1b, 8'h03, 8'h02, 1'b0);
    wr(ADDR_USR_START, 32'h1f03);
    wr(ADDR_USR_END, 32'h010b);
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_CTRL, {25'h0, p[2:0], 4'h1});
      trans(ROWS[p][63:56], ROWS[p][55:48], ROWS[p][47:40],
            ROWS[p][39:32], 1'b1);
      trans(ROWS[p][31:24], ROWS[p][23:16], ROWS[p][15:8],
            ROWS[p][7:0], 1'b0);
      trans(ROWS[p][31:24], ROWS[p][23:16], ROWS[p][15:8],
            ROWS[p][15:8], 1'b0);
    end
    set_clock(8'h05, 8'h01, tm(5'h00, 6'h3b, 6'h3b));
    repeat (6) @(posedge core_clk_i);
    n = far.bcast_seen;
    @(posedge core_clk_i);
    tick_sec_i <= 1'b1;
    @(posedge core_clk_i);
    tick_sec_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk32("hourly count", n + 1, far.bcast_seen);
    chk36("hourly time", {7'h18, 4'h5, 5'h01, 3'h0, 5'h01, 12'h000},
          far.last_bcast);
    far.push({7'h18, 4'h6, 5'h0f, 3'h2, 5'h09, 6'h0f, 6'h1e});
    repeat (4) @(posedge core_clk_i);
    rdc("sync off", ADDR_TIME, tm(5'h01, 6'h00, 6'h00));
    n = far.bcast_seen;
    wr(ADDR_CTRL, 32'h2);
    far.push({7'h18, 4'h6, 5'h0f, 3'h2, 5'h09, 6'h0f, 6'h1e});
    repeat (4) @(posedge core_clk_i);
    rdc("sync time", ADDR_TIME, tm(5'h09, 6'h0f, 6'h1e));
    rdc("sync date", ADDR_DATE, 32'h0218060f);
    chk32("sync no bcast", n, far.bcast_seen);
    wr(ADDR_CTRL, 32'h0);
    close_out();
  end
endmodule : dcc_top_tb_top
`default_nettype wire
